// *** rtl/docr_defines.vh ***
// Constants for the detector option configuration register
`ifndef DOCR_DEFINES_VH
`define DOCR_DEFINES_VH
`define DOCR_WIDTH 39
`define DOCR_OPT_LO 25
`define DOCR_OPT_BITS 14
`define DOCR_TONE_BIT 38
`define DOCR_EOS_BIT 37
`define DOCR_LBS_BIT 36
`define DOCR_SIL_BIT 35
`define DOCR_LTD_BIT 34
`define DOCR_LB_HI 33
`define DOCR_LB_LO 31
`define DOCR_LED_HI 30
`define DOCR_LED_LO 29
`define DOCR_IT_HI 28
`define DOCR_IT_LO 27
`define DOCR_GAIN_HI 26
`define DOCR_GAIN_LO 25
`define DOCR_NL_HI 24
`define DOCR_NL_LO 20
`define DOCR_HY_HI 19
`define DOCR_HY_LO 15
`define DOCR_SL_HI 14
`define DOCR_SL_LO 10
`define DOCR_CT_HI 9
`define DOCR_CT_LO 5
`define DOCR_DR_HI 4
`define DOCR_DR_LO 0
`define DOCR_STORE_MS 10
`define DOCR_CLK_HZ 40000000
`endif

// *** rtl/docr_sync.v ***
// Two-flop synchroniser with edge outputs for one pin
`timescale 1ns/10ps
module docr_sync (
	input wire i_clk,
	input wire i_rst,
	input wire i_pin,
	output wire o_level,
	output wire o_rise,
	output wire o_fall
);
	reg s1_q; // First stage, read only by s2_q
	reg s2_q; // Synchronised level
	reg s3_q; // Previous level for edge finding

	// Sync chain; edges are found after stage two only
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign o_level = s2_q;
	assign o_rise = s2_q & ~s3_q;
	assign o_fall = ~s2_q & s3_q;
endmodule

// *** rtl/docr_top.v ***
// Serial-loaded option and calibration register with decoded fields
// Overview of operation
// - Bit 37 enables end-of-service reporting
// - Battery trip code decodes to threshold
// - LED drive code decodes to current
// - Integration code decodes to window time
// - Amplifier gain equals code plus one
// - Normal threshold from bits 24..20
// - Hysteresis threshold from bits 19..15
// - Silence threshold from bits 14..10
// - Shift data on clock while enable high
// - Option mode loads 14 bits, else 39
// - Store pulse of 10 ms commits register
// - Chamber threshold from bits 9..5
`timescale 1ns/10ps
`include "docr_defines.vh"
module docr_top #(
	parameter STORE_CYC = (`DOCR_STORE_MS * (`DOCR_CLK_HZ / 1000))
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_serial_data_pin,
	input wire i_shift_clock_pin,
	input wire i_program_enable_pin,
	input wire i_store_strobe_pin,
	input wire i_option_load_mode,
	input wire i_smoke_high,
	input wire i_interconnect_alarm,
	input wire i_button_press,
	input wire i_silence_request,
	output reg o_horn_temporal,
	output reg o_end_of_service_en,
	output reg o_lowbatt_silence_en,
	output reg o_long_term_drift_en,
	output reg o_silenced,
	output reg [6:0] o_battery_trip_dv,
	output reg [7:0] o_led_drive_ma,
	output reg [8:0] o_integration_us,
	output reg [2:0] o_amp_gain,
	output reg [4:0] o_normal_threshold,
	output reg [4:0] o_hysteresis_threshold,
	output reg [4:0] o_silence_threshold,
	output reg [4:0] o_chamber_check_threshold,
	output reg [4:0] o_drift_sample,
	output reg o_stored
);
	wire data_lvl; // Synchronised serial data
	wire sck_rise; // Shift clock rising edge
	wire en_lvl; // Synchronised program enable
	wire stb_lvl; // Synchronised store strobe
	wire stb_fall; // Store strobe falling edge
	wire mode_lvl; // Synchronised load mode
	reg [`DOCR_WIDTH-1:0] shift_q; // Serial shift register
	reg [`DOCR_WIDTH-1:0] mem_q; // Committed configuration
	reg [31:0] pw_q; // Store pulse width counter
	reg pw_ok_q; // Pulse was long enough
	reg silenced_q; // Silenced state
	reg btn_d1_q; // Button delay for edge detection

	// Every programming pin passes its own two-flop chain before use.
	// Data and shift clock share the same latency, so a bit is sampled
	// well inside its window and never at the pin's own transition.
	// Serial data level
	docr_sync u_data (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pin(i_serial_data_pin),
		.o_level(data_lvl),
		.o_rise(),
		.o_fall()
	);
	// Shift clock; only its rising edge moves the register
	docr_sync u_sck (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pin(i_shift_clock_pin),
		.o_level(),
		.o_rise(sck_rise),
		.o_fall()
	);
	// Program enable level gates both shifting and storing
	docr_sync u_en (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pin(i_program_enable_pin),
		.o_level(en_lvl),
		.o_rise(),
		.o_fall()
	);
	// Store strobe; its width is timed and its fall commits
	docr_sync u_stb (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pin(i_store_strobe_pin),
		.o_level(stb_lvl),
		.o_rise(),
		.o_fall(stb_fall)
	);
	// Load mode level picks the 14-bit or the 39-bit frame
	docr_sync u_mode (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pin(i_option_load_mode),
		.o_level(mode_lvl),
		.o_rise(),
		.o_fall()
	);

	// Low-battery threshold in tenths of a volt; code order is bit-reversed
	function [6:0] lb_decode;
		input [2:0] c;
		begin
			case (c)
				3'h0: lb_decode = 7'h15;
				3'h1: lb_decode = 7'h19;
				3'h2: lb_decode = 7'h17;
				3'h3: lb_decode = 7'h1b;
				3'h4: lb_decode = 7'h16;
				3'h5: lb_decode = 7'h1a;
				3'h6: lb_decode = 7'h18;
				default: lb_decode = 7'h1c;
			endcase
		end
	endfunction

	// Shift register: LSB-first stream enters at the top and moves down.
	// Option mode shifts only the upper 14-bit window, so bit 25 ends up lowest.
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			shift_q <= {`DOCR_WIDTH{1'b0}};
		end else if (en_lvl && sck_rise) begin
			if (mode_lvl) begin
				shift_q[`DOCR_WIDTH-1:`DOCR_OPT_LO] <=
					{data_lvl, shift_q[`DOCR_WIDTH-1:`DOCR_OPT_LO+1]};
			end else begin
				shift_q <= {data_lvl, shift_q[`DOCR_WIDTH-1:1]};
			end
		end
	end

	// Store pulse width; a short pulse is ignored as a glitch
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pw_q <= 32'h0000_0000;
			pw_ok_q <= 1'b0;
		end else if (stb_lvl) begin
			if (pw_q >= STORE_CYC - 1) begin
				pw_ok_q <= 1'b1;
			end else begin
				pw_q <= pw_q + 32'h0000_0001;
			end
		end else begin
			pw_q <= 32'h0000_0000;
			pw_ok_q <= (stb_fall) ? pw_ok_q : 1'b0;
		end
	end

	// Commit on strobe fall after a long enough high pulse
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mem_q <= {`DOCR_WIDTH{1'b0}};
			o_stored <= 1'b0;
		end else begin
			o_stored <= 1'b0;
			if (en_lvl && stb_fall && pw_ok_q) begin
				if (mode_lvl) begin
					mem_q[`DOCR_WIDTH-1:`DOCR_OPT_LO] <=
						shift_q[`DOCR_WIDTH-1:`DOCR_OPT_LO];
				end else begin
					mem_q <= shift_q;
				end
				o_stored <= 1'b1;
			end
		end
	end

	// Silenced state; cancel only when the option allows it
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			silenced_q <= 1'b0;
			btn_d1_q <= 1'b0;
		end else begin
			btn_d1_q <= i_button_press;
			if (!silenced_q) begin
				silenced_q <= i_silence_request;
			end else if (mem_q[`DOCR_SIL_BIT] && (i_smoke_high || i_interconnect_alarm ||
				(i_button_press && !btn_d1_q))) begin
				silenced_q <= 1'b0;
			end
		end
	end

	// Registered decoded outputs
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_horn_temporal <= 1'b0;
			o_end_of_service_en <= 1'b0;
			o_lowbatt_silence_en <= 1'b0;
			o_long_term_drift_en <= 1'b0;
			o_silenced <= 1'b0;
			// Reset shows the decode of an all-zero memory
			o_battery_trip_dv <= 7'h15;
			o_led_drive_ma <= 8'h32;
			o_integration_us <= 9'h190;
			o_amp_gain <= 3'h1;
			o_normal_threshold <= 5'h00;
			o_hysteresis_threshold <= 5'h00;
			o_silence_threshold <= 5'h00;
			o_chamber_check_threshold <= 5'h00;
			o_drift_sample <= 5'h00;
		end else begin
			o_horn_temporal <= mem_q[`DOCR_TONE_BIT];
			o_end_of_service_en <= mem_q[`DOCR_EOS_BIT];
			o_lowbatt_silence_en <= mem_q[`DOCR_LBS_BIT];
			o_long_term_drift_en <= mem_q[`DOCR_LTD_BIT];
			o_silenced <= silenced_q;
			o_battery_trip_dv <= lb_decode(mem_q[`DOCR_LB_HI:`DOCR_LB_LO]);
			// Steps of 50 mA; the top code gives 200, which still fits 8 bits
			o_led_drive_ma <= 8'h32 * ({6'h00, mem_q[`DOCR_LED_HI:`DOCR_LED_LO]}
				+ 8'h01);
			// Longer codes shorten the window in 100 us steps
			o_integration_us <= 9'h190 - 9'h064 *
				{7'h00, mem_q[`DOCR_IT_HI:`DOCR_IT_LO]};
			o_amp_gain <= {1'b0, mem_q[`DOCR_GAIN_HI:`DOCR_GAIN_LO]} + 3'h1;
			o_normal_threshold <= mem_q[`DOCR_NL_HI:`DOCR_NL_LO];
			o_hysteresis_threshold <= mem_q[`DOCR_HY_HI:`DOCR_HY_LO];
			o_silence_threshold <= mem_q[`DOCR_SL_HI:`DOCR_SL_LO];
			o_chamber_check_threshold <= mem_q[`DOCR_CT_HI:`DOCR_CT_LO];
			o_drift_sample <= mem_q[`DOCR_DR_HI:`DOCR_DR_LO];
		end
	end
endmodule

// *** dv/docr_prog.sv ***
// Programmer model for the serial load pins
`timescale 1ns/10ps
module docr_prog (
	input wire i_clk,
	output reg o_sdat,
	output reg o_sck,
	output reg o_en,
	output reg o_stb
);
	initial {o_sdat, o_sck, o_en, o_stb} = 4'h0;
	// LSB first from bit lo; the 200 ns clock runs only inside a frame
	task send(input [38:0] v, input int lo, input int n, input bit en);
		o_en = en;
		for (int b = 0; b < n; b++) begin
			o_sdat = v[lo + b];
			#100 o_sck = 1'b1;
			#100 o_sck = 1'b0;
		end
		o_sdat = ~o_sdat; // Released data never shows the last bit
		o_en = 1'b1;
	endtask
	// Strobe high for cyc clocks, commit on its fall
	task store(input int cyc);
		o_stb = 1'b1;
		repeat (cyc) @(negedge i_clk);
		o_stb = 1'b0;
		repeat (8) @(negedge i_clk);
	endtask
endmodule

// *** dv/docr_chk.sv ***
// Checker for the decoded option outputs
`timescale 1ns/10ps
module docr_chk (
	input wire i_clk,
	input wire i_rst,
	input wire i_store_strobe_pin,
	input wire i_silence_request,
	input wire o_stored,
	input wire o_silenced,
	input wire [6:0] o_battery_trip_dv,
	input wire [7:0] o_led_drive_ma,
	input wire [8:0] o_integration_us,
	input wire [2:0] o_amp_gain,
	input wire [4:0] o_normal_threshold
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// A strobe that was high six clocks back and low three clocks back
	sequence strobe_done_s;
		$past(i_store_strobe_pin, 6) && !$past(i_store_strobe_pin, 3);
	endsequence
	store_pulse_a: assert property (o_stored |=> !o_stored) else $error("store pulse long");
	store_cause_a: assert property (o_stored |-> strobe_done_s) else $error("bad store");
	gain_set_a: assert property (o_amp_gain inside {1, 2, 3, 4}) else $error("gain");
	led_set_a: assert property (o_led_drive_ma inside {50, 100, 150, 200}) else $error("led");
	integ_set_a: assert property (o_integration_us inside {100, 200, 300, 400}) else $error("it");
	batt_set_a: assert property (o_battery_trip_dv inside {[21:28]}) else $error("batt");
	limit_hold_a: assert property (!$past(o_stored) |-> $stable(o_normal_threshold))
		else $error("limit moved");
	sil_entry_a: assert property ($rose(o_silenced) |-> $past(i_silence_request, 2))
		else $error("silenced");
endmodule

// *** dv/tb_detector_option_config_register.sv ***
// Bench for the detector option configuration register
`timescale 1ns/10ps
module tb_detector_option_config_register;
	logic i_clk = 1'b0, i_rst = 1'b1, i_smoke_high = 1'b0, i_silence_request = 1'b0, mode = 1'b0;
	wire sdat, sck, en, stb, o_horn_temporal, o_end_of_service_en, o_lowbatt_silence_en;
	wire o_long_term_drift_en, o_silenced, o_stored;
	wire [6:0] o_battery_trip_dv;
	wire [7:0] o_led_drive_ma;
	wire [8:0] o_integration_us;
	wire [4:0] o_normal_threshold, o_hysteresis_threshold, o_silence_threshold;
	wire [4:0] o_chamber_check_threshold, o_drift_sample;
	wire [2:0] o_amp_gain;
	logic i_interconnect_alarm = 1'b0, i_button_press = 1'b0;
	logic [38:0] q[$], cur, e;
	logic [31:0] seed = 32'h0000_0052;
	int error_cnt = 0, tests_run = 0, lbt[8] = '{21, 25, 23, 27, 22, 26, 24, 28};
	always #12.5 i_clk = ~i_clk;
	docr_prog u_prog (.i_clk, .o_sdat(sdat), .o_sck(sck), .o_en(en), .o_stb(stb));
	docr_top #(.STORE_CYC(20)) DUT (.i_clk, .i_rst, .i_serial_data_pin(sdat),
		.i_shift_clock_pin(sck), .i_program_enable_pin(en), .i_store_strobe_pin(stb),
		.i_option_load_mode(mode), .i_smoke_high, .i_interconnect_alarm,
		.i_button_press, .i_silence_request, .o_horn_temporal, .o_end_of_service_en,
		.o_lowbatt_silence_en, .o_long_term_drift_en, .o_silenced, .o_battery_trip_dv,
		.o_led_drive_ma, .o_integration_us, .o_amp_gain, .o_normal_threshold,
		.o_hysteresis_threshold, .o_silence_threshold, .o_chamber_check_threshold,
		.o_drift_sample, .o_stored);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic cmp(input string n, input logic [8:0] x, input logic [8:0] g);
		tests_run++;
		if (g !== x) begin
			error_cnt++;
			$display("MISMATCH %s exp %0d got %0d", n, x, g);
		end
	endtask
	task finish_test();
		if (error_cnt == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Each commit is matched with the oldest noted image, once outputs settle
	always @(negedge i_clk) if (o_stored === 1'b1) begin
		@(negedge i_clk);
		cmp("pending", 9'h001, {8'h00, q.size() != 0});
		e = q.pop_front();
		cmp("tone", e[38], o_horn_temporal);
		cmp("eos", e[37], o_end_of_service_en);
		cmp("lbsil", e[36], o_lowbatt_silence_en);
		cmp("drift_en", e[34], o_long_term_drift_en);
		cmp("drift", e[4:0], o_drift_sample);
		cmp("batt", lbt[e[33:31]], o_battery_trip_dv);
		cmp("led", 50 * (e[30:29] + 1), o_led_drive_ma);
		cmp("integ", 400 - 100 * e[28:27], o_integration_us);
		cmp("gain", e[26:25] + 1, o_amp_gain);
		cmp("normal", e[24:20], o_normal_threshold);
		cmp("hyst", e[19:15], o_hysteresis_threshold);
		cmp("silence", e[14:10], o_silence_threshold);
		cmp("chamber", e[9:5], o_chamber_check_threshold);
	end
	// Hang guard, well past the expected run of about 78 us
	initial begin
		#500_000;
		error_cnt++;
		finish_test();
	end
	initial begin
		repeat (3) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (4) @(negedge i_clk);
		// Every decode code at least once, random limits, full 39-bit loads
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			cur = {seed[6:0], seed};
			cur[33:25] = {i[2:0], i[1:0], i[1:0], i[1:0]};
			cur[35] = i[0]; // Cancel option alternates against each cause
			q.push_back(cur);
			u_prog.send(cur, 0, 39, 1'b1);
			u_prog.store(25);
			i_silence_request = 1'b1;
			@(negedge i_clk);
			i_silence_request = 1'b0;
			// Rotate the cancel cause over smoke, interconnect and button
			i_smoke_high = (i % 3 == 0);
			i_interconnect_alarm = (i % 3 == 1);
			i_button_press = (i % 3 == 2);
			@(negedge i_clk);
			{i_smoke_high, i_interconnect_alarm, i_button_press} = 3'h0;
			repeat (3) @(negedge i_clk);
			cmp("silenced", !cur[35], o_silenced);
		end
		// Option mode keeps the low 25 stored bits
		mode = 1'b1;
		seed = xs(seed);
		cur = {seed[13:0], cur[24:0]};
		q.push_back(cur);
		u_prog.send(cur, 25, 14, 1'b1);
		u_prog.store(25);
		// Shifts without enable and a short strobe change nothing
		u_prog.send(~cur, 25, 14, 1'b0);
		u_prog.store(10);
		q.push_back(cur);
		u_prog.store(25);
		cmp("unstored", 9'h000, q.size());
		finish_test();
	end
endmodule
bind docr_top docr_chk u_chk (.i_clk, .i_rst, .i_store_strobe_pin, .i_silence_request,
	.o_stored, .o_silenced, .o_battery_trip_dv, .o_led_drive_ma, .o_integration_us,
	.o_amp_gain, .o_normal_threshold);
